// ---- core/iseq_pkg.sv ----
package iseq_pkg;
   // Bus widths
   localparam int IA_W   = 20;
   localparam int DW     = 16;
   localparam int OAW    = 16;
   localparam int SAVE_W = 32;
   localparam int NSYNC  = 4;
   // Sync pin slots
   localparam int PIN_BUSY  = 0;
   localparam int PIN_GRANT = 1;
   localparam int PIN_ACK   = 2;
   localparam int PIN_TOUT  = 3;
   localparam int PIN_PROT  = 4;
   localparam int NPIN      = 5;
   // One tick of clk_i is half a processor clock
   localparam int PHASE_HALF   = 1;
   localparam int PHASE_STRETCH = 3;
   localparam int DS_AFTER_P3  = 2;
   localparam logic [1:0] END_SHORT = 2'(PHASE_HALF - 1);
   localparam logic [1:0] END_LONG  = 2'(PHASE_STRETCH - 1);
   localparam logic [1:0] DS_TICK   = 2'(DS_AFTER_P3 - PHASE_HALF);
   localparam logic [1:0] CNT_ZERO  = 2'h0;
   localparam logic [1:0] CNT_ONE   = 2'h1;
   // Reset values
   localparam logic [IA_W-1:0] IC_RESET = 20'h00000;
   localparam logic [IA_W-1:0] IC_STEP  = 20'h00001;
   localparam logic [DW-1:0]   NOP_WORD = 16'h0000;
   localparam logic [SAVE_W-IA_W-1:0] SAVE_PAD = 12'h000;
   typedef enum logic [1:0] {
      PH_ONE,
      PH_TWO,
      PH_THREE,
      PH_FOUR
   } iseq_phase_t;
endpackage

// ---- core/iseq_top.sv ----
`timescale 1ns/1ps
module iseq_top (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire logic                 ce_i,
   input  wire logic                 op_store_i,
   input  wire logic                 op_load_i,
   input  wire logic                 op_long_imm_i,
   input  wire logic                 op_operand_i,
   input  wire logic                 op_op_read_i,
   input  wire logic                 op_op_mem_i,
   input  wire logic [15:0]          op_op_addr_i,
   input  wire logic [15:0]          op_op_wdata_i,
   input  wire logic                 flow_change_i,
   input  wire logic [19:0]          flow_target_i,
   input  wire logic [19:0]          work_register_i,
   input  wire logic [15:0]          store_data_i,
   input  wire logic                 save_read_i,
   output logic      [31:0]          save_read_data_o,
   output logic      [15:0]          execute_insn_o,
   output logic      [15:0]          load_data_o,
   output logic                      load_valid_o,
   output logic                      bus_error_o,
   output logic      [1:0]           phase_o,
   output logic      [19:0]          insn_addr_bus_o,
   input  wire logic [15:0]          insn_data_bus_i,
   output logic      [15:0]          insn_data_bus_o,
   output logic                      insn_data_bus_oe_o,
   output logic                      insn_read_strobe_n_o,
   output logic                      insn_write_strobe_n_o,
   output logic                      execute_phase_flag_o,
   input  wire logic                 bus_busy_n_i,
   input  wire logic                 grant_in_n_i,
   input  wire logic                 transfer_ack_n_i,
   input  wire logic                 bus_timeout_err_n_i,
   input  wire logic                 protect_fault_n_i,
   output logic                      master_hold_n_o,
   output logic                      mem_or_io_select_o,
   output logic                      read_not_write_o,
   output logic                      data_strobe_n_o,
   output logic      [15:0]          operand_addr_o,
   output logic      [15:0]          operand_data_o,
   output logic                      operand_oe_o
);
   logic [1:0]            rst_q;
   logic                  rst_n;
   logic [iseq_pkg::NPIN-1:0] pin_raw;
   logic [iseq_pkg::NPIN-1:0] pin_f;
   iseq_pkg::iseq_phase_t phase;
   iseq_pkg::iseq_phase_t next_phase;
   logic [1:0]            cnt;
   logic [19:0]           instruction_counter;
   logic [19:0]           return_address_save;
   logic [15:0]           primary_insn_latch;
   logic [15:0]           execute_insn_latch;
   logic                  cur_st, cur_ld, cur_limm, cur_op;
   logic                  cur_rd, cur_mem, cur_br;
   logic [19:0]           cur_tgt;
   logic [19:0]           next_counter;
   logic [15:0]           cur_oa, cur_od;
   logic                  grant_ok, ack_seen, err_seen;
   logic                  p2_done, p4_done;
   logic                  ldst, ldst_nx, st_nx;

   // Reset release through two flops, assert is asynchronous
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // Pins from other clock domains, three flops and agreement
   assign pin_raw = {protect_fault_n_i, bus_timeout_err_n_i,
                     transfer_ack_n_i, grant_in_n_i, bus_busy_n_i};
   for (genvar g = 0; g < iseq_pkg::NPIN; g++) begin : g_sync
      logic [2:0] s;
      logic       f;
      always_ff @(posedge clk_i or negedge rst_n) begin
         if (!rst_n) begin
            s <= 3'h7;
            f <= 1'b1;
         end else if (ce_i) begin
            s <= {s[1:0], pin_raw[g]};
            if (s[1] == s[2]) begin // Filter glitches
               f <= s[2];
            end
         end
      end
      // One flop per slot, so each bit has a single driver
      assign pin_f[g] = f;
   end

   // Ownership: busy pin high and grant low
   assign grant_ok = pin_f[iseq_pkg::PIN_BUSY] &
                     ~pin_f[iseq_pkg::PIN_GRANT];
   assign ack_seen = ~pin_f[iseq_pkg::PIN_ACK];
   assign err_seen = ~pin_f[iseq_pkg::PIN_TOUT] |
                     ~pin_f[iseq_pkg::PIN_PROT];
   assign ldst     = cur_st | cur_ld;
   // Entering phase two the decode flops still hold the last instruction
   assign st_nx    = (phase == iseq_pkg::PH_ONE) ? op_store_i : cur_st;
   assign ldst_nx  = (phase == iseq_pkg::PH_ONE) ?
                     (op_store_i | op_load_i) : ldst;
   // Next fetch address, so it is already valid as phase one opens
   assign next_counter = cur_br ? cur_tgt :
                         instruction_counter + iseq_pkg::IC_STEP;

   // Phase two: short, stretched, then arbitration wait
   assign p2_done = (cnt == ((ldst | cur_op) ? iseq_pkg::END_LONG
                             : iseq_pkg::END_SHORT))
                    && (!cur_op || grant_ok);

   // Phase four: short or stretched, or for an operand access an acknowledge wait
   always_comb begin
      p4_done = (cnt == ((ldst | cur_limm) ? iseq_pkg::END_LONG
                         : iseq_pkg::END_SHORT));
      if (cur_op) begin
         // Ack only counts once the strobe is out
         p4_done = !data_strobe_n_o &&
                   (ack_seen || err_seen);
      end
   end

   // Phase sequencing, no wait input on the fetch side
   always_comb begin
      next_phase = phase;
      case (phase)
         iseq_pkg::PH_ONE: begin
            next_phase = iseq_pkg::PH_TWO;
         end
         iseq_pkg::PH_TWO: begin
            if (p2_done) begin
               next_phase = iseq_pkg::PH_THREE;
            end
         end
         iseq_pkg::PH_THREE: begin
            next_phase = iseq_pkg::PH_FOUR;
         end
         iseq_pkg::PH_FOUR: begin
            if (p4_done) begin
               next_phase = iseq_pkg::PH_ONE;
            end
         end
         default: begin
            next_phase = iseq_pkg::PH_ONE;
         end
      endcase
   end

   // Phase register and tick counter within a phase
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         phase <= iseq_pkg::PH_ONE;
         cnt   <= iseq_pkg::CNT_ZERO;
      end else if (ce_i) begin
         phase <= next_phase;
         if (next_phase != phase) begin
            cnt <= iseq_pkg::CNT_ZERO;
         end else if (cnt != iseq_pkg::END_LONG) begin
            cnt <= cnt + iseq_pkg::CNT_ONE; // Saturates
         end
      end
   end
   assign phase_o = phase;

   // Decode of the instruction entering execution
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cur_st   <= 1'b0;
         cur_ld   <= 1'b0;
         cur_limm <= 1'b0;
         cur_op   <= 1'b0;
         cur_rd   <= 1'b1;
         cur_mem  <= 1'b1;
         cur_br   <= 1'b0;
         cur_tgt  <= iseq_pkg::IC_RESET;
         cur_oa   <= 16'h0000;
         cur_od   <= 16'h0000;
      end else if (ce_i && phase == iseq_pkg::PH_ONE) begin
         cur_st   <= op_store_i;
         cur_ld   <= op_load_i;
         cur_limm <= op_long_imm_i;
         cur_op   <= op_operand_i;
         cur_rd   <= op_op_read_i;
         cur_mem  <= op_op_mem_i;
         cur_br   <= flow_change_i;
         cur_tgt  <= flow_target_i;
         cur_oa   <= op_op_addr_i;
         cur_od   <= op_op_wdata_i;
      end
   end

   // Two latch stages; fetch overlaps execute
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         primary_insn_latch <= iseq_pkg::NOP_WORD;
         execute_insn_latch <= iseq_pkg::NOP_WORD;
      end else if (ce_i) begin
         if (phase == iseq_pkg::PH_ONE) begin
            execute_insn_latch <= primary_insn_latch;
         end
         if (phase == iseq_pkg::PH_FOUR) begin
            // Transparent while phase four is open
            primary_insn_latch <= insn_data_bus_i;
         end
      end
   end
   assign execute_insn_o = execute_insn_latch;

   // Counter advances at phase four end; a branch only
   // redirects the fetch after the slot word is in
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         instruction_counter <= iseq_pkg::IC_RESET;
      end else if (ce_i && phase == iseq_pkg::PH_FOUR && p4_done) begin
         instruction_counter <= next_counter;
      end
   end

   // Save register, overwritten by each flow change
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         return_address_save <= iseq_pkg::IC_RESET;
      end else if (ce_i && phase == iseq_pkg::PH_ONE && flow_change_i) begin
         return_address_save <= instruction_counter;
      end
   end

   // Read port pads to a register pair width
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         save_read_data_o <= 32'h00000000;
      end else if (ce_i && save_read_i) begin
         save_read_data_o <= {iseq_pkg::SAVE_PAD,
                              return_address_save};
      end
   end

   // Instruction port address, data and strobes
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         insn_addr_bus_o       <= iseq_pkg::IC_RESET;
         insn_data_bus_o       <= iseq_pkg::NOP_WORD;
         insn_data_bus_oe_o    <= 1'b0;
         insn_read_strobe_n_o  <= 1'b1;
         insn_write_strobe_n_o <= 1'b1;
      end else if (ce_i) begin
         insn_read_strobe_n_o  <= 1'b0;
         insn_write_strobe_n_o <= 1'b1;
         insn_data_bus_oe_o    <= 1'b0;
         if (next_phase == iseq_pkg::PH_ONE) begin
            insn_addr_bus_o    <= next_counter;
         end else begin
            insn_addr_bus_o    <= instruction_counter;
         end
         if (next_phase == iseq_pkg::PH_ONE && op_store_i) begin
            insn_addr_bus_o       <= work_register_i;
            insn_read_strobe_n_o  <= 1'b1;
            insn_write_strobe_n_o <= 1'b0;
            insn_data_bus_o       <= store_data_i;
            insn_data_bus_oe_o    <= 1'b1;
         end else if (next_phase == iseq_pkg::PH_ONE && op_load_i) begin
            insn_addr_bus_o <= work_register_i;
         end else if (next_phase == iseq_pkg::PH_TWO && ldst_nx) begin
            // Hold access through the stretched phase two
            insn_addr_bus_o       <= insn_addr_bus_o;
            insn_read_strobe_n_o  <= st_nx;
            insn_write_strobe_n_o <= ~st_nx;
            insn_data_bus_oe_o    <= st_nx;
         end
      end
   end

   // Load word taken at the last tick of phase two
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         load_data_o  <= iseq_pkg::NOP_WORD;
         load_valid_o <= 1'b0;
      end else if (ce_i) begin
         load_valid_o <= 1'b0;
         if (phase == iseq_pkg::PH_TWO && cur_ld && p2_done) begin
            load_data_o  <= insn_data_bus_i;
            load_valid_o <= 1'b1;
         end
      end
   end

   // Execute flag: low in one and two, high in three and four
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         execute_phase_flag_o <= 1'b0;
      end else if (ce_i) begin
         execute_phase_flag_o <= (next_phase == iseq_pkg::PH_THREE) ||
            (next_phase == iseq_pkg::PH_FOUR);
      end
   end

   // Operand bus, owned from phase three to cycle end
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         master_hold_n_o    <= 1'b1;
         mem_or_io_select_o <= 1'b1;
         read_not_write_o   <= 1'b1;
         operand_addr_o     <= 16'h0000;
         operand_data_o     <= 16'h0000;
         operand_oe_o       <= 1'b0;
         data_strobe_n_o    <= 1'b1;
         bus_error_o        <= 1'b0;
      end else if (ce_i) begin
         bus_error_o <= 1'b0;
         if (phase == iseq_pkg::PH_TWO && p2_done && cur_op) begin
            master_hold_n_o    <= 1'b0;
            mem_or_io_select_o <= cur_mem;
            read_not_write_o   <= cur_rd;
            operand_addr_o     <= cur_oa;
            operand_data_o     <= cur_od;
            operand_oe_o       <= 1'b1;
         end
         if (phase == iseq_pkg::PH_FOUR && cur_op &&
             cnt == iseq_pkg::CNT_ZERO && data_strobe_n_o) begin
            data_strobe_n_o <= 1'b0;
         end
         if (phase == iseq_pkg::PH_FOUR && p4_done && cur_op) begin
            // Release half a clock after the ack edge
            data_strobe_n_o <= 1'b1;
            master_hold_n_o <= 1'b1;
            operand_oe_o    <= 1'b0;
            bus_error_o     <= err_seen;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_p1_short;
      phase == iseq_pkg::PH_ONE && ce_i && !op_store_i &&
      !op_load_i && !op_operand_i;
   endsequence
   sequence s_two_ce;
      ce_i ##1 ce_i;
   endsequence

   property p_flag_low;
      phase == iseq_pkg::PH_TWO |-> !execute_phase_flag_o;
   endproperty
   a_flag_low: assert property (p_flag_low)
      else $error("flag high in phase two");

   property p_flag_high;
      phase == iseq_pkg::PH_FOUR |-> execute_phase_flag_o;
   endproperty
   a_flag_high: assert property (p_flag_high)
      else $error("flag low in phase four");

   property p_strobes;
      !(insn_read_strobe_n_o == 1'b0 && insn_write_strobe_n_o == 1'b0);
   endproperty
   a_strobes: assert property (p_strobes)
      else $error("both strobes asserted");

   property p_short_p2;
      s_p1_short ##1 ce_i |=> phase == iseq_pkg::PH_THREE;
   endproperty
   a_short_p2: assert property (p_short_p2)
      else $error("short phase two not one tick");

   property p_long_p2;
      phase == iseq_pkg::PH_TWO && cnt == iseq_pkg::CNT_ZERO &&
      ldst && ce_i |=> phase == iseq_pkg::PH_TWO;
   endproperty
   a_long_p2: assert property (p_long_p2)
      else $error("phase two not stretched");

   property p_save;
      phase == iseq_pkg::PH_ONE && ce_i && flow_change_i |=>
      return_address_save == $past(instruction_counter);
   endproperty
   a_save: assert property (p_save)
      else $error("counter not saved");

   property p_ack_end;
      phase == iseq_pkg::PH_FOUR && cur_op && !data_strobe_n_o &&
      ack_seen && ce_i |=> phase == iseq_pkg::PH_ONE && data_strobe_n_o;
   endproperty
   a_ack_end: assert property (p_ack_end)
      else $error("cycle did not end on ack");

   property p_ds_time;
      phase == iseq_pkg::PH_THREE && cur_op && ce_i ##0 s_two_ce
      |-> ##1 !data_strobe_n_o;
   endproperty
   a_ds_time: assert property (p_ds_time)
      else $error("strobe not one clock after phase three");

   property p_hold;
      phase == iseq_pkg::PH_THREE && cur_op |-> !master_hold_n_o;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold not driven in phase three");
endmodule

// ---- tb/iseq_imem_model.sv ----
`timescale 1ns/1ps
// Zero-wait instruction memory seen from the instruction port pins
module iseq_imem_model (
   input  wire logic        slow_i,
   input  wire logic [19:0] addr_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   input  wire logic        oe_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o
);
   logic [15:0] mem [logic [19:0]];
   logic [15:0] word;
   logic [15:0] last;
   logic [15:0] word_late;
   logic [36:0] wq;
   // Unwritten words hold an address pattern the bench can predict
   always @* begin
      word = mem.exists(addr_i) ? mem[addr_i] : addr_i[15:0] ^ 16'h5A3C;
   end
   // Late copy, so the closing strobe edge still sees its own address
   assign #1 wq = {oe_i, addr_i, wdata_i};
   // Word lands when the write strobe is released
   always @(posedge wr_n_i) begin
      if (wq[36]) mem[wq[35:16]] = wq[15:0];
   end
   // Remember the last word so a released bus shows its inverse
   always @* begin
      if (!rd_n_i) last = word;
   end
   assign #4 word_late = word;
   // No wait states: even the slow answer settles within one tick
   assign rdata_o = rd_n_i ? ~last : (slow_i ? word_late : word);
endmodule

// ---- tb/iseq_top_tb.sv ----
`timescale 1ns/1ps
// Drives the sequencer instruction by instruction and judges each phase
module iseq_top_tb;
   logic        clk_i, reset_n_i, ce_i, op_store_i, op_load_i;
   logic        op_long_imm_i, op_operand_i, op_op_read_i, op_op_mem_i;
   logic        flow_change_i, save_read_i, load_valid_o, bus_error_o;
   logic        insn_read_strobe_n_o, insn_write_strobe_n_o, slow;
   logic        insn_data_bus_oe_o, execute_phase_flag_o, bus_busy_n_i;
   logic        grant_in_n_i, transfer_ack_n_i, bus_timeout_err_n_i;
   logic        protect_fault_n_i, master_hold_n_o, mem_or_io_select_o;
   logic        read_not_write_o, data_strobe_n_o, operand_oe_o, lv_seen;
   logic        be_seen;
   logic [1:0]  phase_o;
   logic [2:0]  p1;
   logic [4:0]  pins, pins_nx, pre_nx;
   logic [7:0]  rv;
   logic [15:0] op_op_addr_i, op_op_wdata_i, store_data_i, execute_insn_o;
   logic [15:0] load_data_o, insn_data_bus_i, insn_data_bus_o, mem_rdata;
   logic [15:0] operand_addr_o, operand_data_o, p1d, ld;
   logic [19:0] flow_target_i, work_register_i, insn_addr_bus_o, fa, p1a;
   logic [31:0] save_read_data_o;
   logic [33:0] op_nx;
   logic [35:0] ld_nx;
   int          errors, cmp_count, n2, n4, ticks, act_at;
   localparam int HB = 6;

   iseq_top i_dut (.*);
   iseq_imem_model i_mem (
      .slow_i  (slow),
      .addr_i  (insn_addr_bus_o),
      .rd_n_i  (insn_read_strobe_n_o),
      .wr_n_i  (insn_write_strobe_n_o),
      .oe_i    (insn_data_bus_oe_o),
      .wdata_i (insn_data_bus_o),
      .rdata_o (mem_rdata)
   );
   // Wire level of the shared instruction data lines
   assign insn_data_bus_i = insn_data_bus_oe_o ? insn_data_bus_o : mem_rdata;
   // Operand-port pins: busy, grant, ack, timeout, protect
   assign {bus_busy_n_i, grant_in_n_i, transfer_ack_n_i, bus_timeout_err_n_i,
           protect_fault_n_i} = pins;

   // Clock generator
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One tick; pin changes land on the edge, outputs read once settled
   task automatic tk;
      @(posedge clk_i);
      if (ticks == act_at) pins <= pins_nx;
      ticks++;
      #1;
      if (load_valid_o === 1'b1) lv_seen = 1'b1;
      if (load_valid_o === 1'b1) ld = load_data_o;
      if (bus_error_o === 1'b1) be_seen = 1'b1;
      chk("flag", execute_phase_flag_o, phase_o[1]);
   endtask

   // Bounded wait for a phase; a hang ends the run
   task automatic wait_ph(logic [1:0] ph, output int n);
      n = 0;
      while (phase_o !== ph) begin
         tk;
         n++;
         if (n > 60) begin
            errors++;
            $display("[ERR] phase wait expected %h seen %h", ph, phase_o);
            stop_test;
         end
      end
   endtask

   // Issue one instruction at the close of the previous phase three
   task automatic exec(logic [3:0] kind, logic fl, logic [19:0] tgt);
      int         n;
      logic [2:0] fc;
      wait_ph(2'h2, n);
      @(posedge clk_i);
      {op_store_i, op_load_i, op_long_imm_i, op_operand_i} <= kind;
      {flow_change_i, flow_target_i} <= {fl, tgt};
      {work_register_i, store_data_i} <= ld_nx;
      {op_op_read_i, op_op_mem_i, op_op_addr_i, op_op_wdata_i} <= op_nx;
      pins <= pre_nx;
      ticks++;
      #1;
      wait_ph(2'h0, n4);
      p1 = {insn_read_strobe_n_o, insn_write_strobe_n_o, insn_data_bus_oe_o};
      p1a = insn_addr_bus_o;
      p1d = insn_data_bus_o;
      // Decode is taken at the end of phase one only
      @(posedge clk_i);
      {op_store_i, op_load_i, op_long_imm_i, op_operand_i} <= 4'h0;
      flow_change_i <= 1'b0;
      ticks++;
      act_at = ticks + HB;
      pins_nx = 5'b10111;
      #1;
      wait_ph(2'h2, n2);
      fa = insn_addr_bus_o;
      fc = {insn_read_strobe_n_o, insn_write_strobe_n_o, insn_data_bus_oe_o};
      chk("fetch ctl", fc, 3'b010);
   endtask

   // Plain then long immediate: phase lengths and fetch pipeline
   task automatic s_seq;
      logic [19:0] a;
      exec(4'h0, 1'b0, 20'h0);
      a = fa;
      exec(4'h2, 1'b0, 20'h0);
      chk("p4 short", n4, 1);
      chk("p2 short", n2, 1);
      chk("p1 addr", p1a, a + 20'h1);
      chk("fetch", fa, a + 20'h1);
      chk("exec word", execute_insn_o, a[15:0] ^ 16'h5A3C);
      exec(4'h0, 1'b0, 20'h0);
      chk("p4 long", n4, 3);
   endtask

   // Store a word, then read it back with a slow memory answer
   task automatic s_mem;
      ld_nx = {20'h80010, 16'hC3A5};
      exec(4'h8, 1'b0, 20'h0);
      chk("st p1", {p1, p1a, p1d}, {3'b101, 20'h80010, 16'hC3A5});
      chk("st p2", n2, 3);
      slow = 1'b1;
      lv_seen = 1'b0;
      exec(4'h4, 1'b0, 20'h0);
      chk("st p4", n4, 3);
      chk("ld p1", {p1, p1a}, {3'b010, 20'h80010});
      chk("ld p2", n2, 3);
      exec(4'h0, 1'b0, 20'h0);
      chk("ld p4", n4, 3);
      chk("ld data", {lv_seen, ld}, {1'b1, 16'hC3A5});
      slow = 1'b0;
   endtask

   // Two branches: delay slot, target fetch, save overwritten
   task automatic s_branch;
      logic [19:0] a;
      exec(4'h0, 1'b0, 20'h0);
      a = fa;
      exec(4'h0, 1'b1, 20'h3C5A0);
      chk("slot", fa, a + 20'h1);
      exec(4'h0, 1'b0, 20'h0);
      chk("target", fa, 20'h3C5A0);
      chk("save", save_read_data_o, {12'h000, a + 20'h1});
      exec(4'h0, 1'b1, 20'h01234);
      exec(4'h0, 1'b0, 20'h0);
      chk("target 2", fa, 20'h01234);
      chk("resave", save_read_data_o, 32'h0003C5A1);
   endtask

   // Operand access, arbitration optionally withheld, ack or fault ends it
   task automatic s_opnd(logic [4:0] pre, logic [4:0] endv, logic [33:0] o);
      int          n;
      logic [18:0] ob;
      {pre_nx, op_nx} = {pre, o};
      exec(4'h1, 1'b0, 20'h0);
      pre_nx = 5'b10111;
      if (pre == 5'b10111) chk("op p2", n2, 3);
      else chk("arb p2", n2 > HB + 1 && n2 <= HB + 9, 1'b1);
      ob = {master_hold_n_o, read_not_write_o, mem_or_io_select_o,
            operand_addr_o};
      chk("p3 bus", ob, {1'b0, o[33:16]});
      chk("p3 data", {operand_oe_o, operand_data_o}, {1'b1, o[15:0]});
      tk;
      chk("ds early", data_strobe_n_o, 1'b1);
      tk;
      chk("ds", data_strobe_n_o, 1'b0);
      repeat (6) tk;
      chk("ack wait", {phase_o, data_strobe_n_o}, 3'b110);
      // Responder always answers, with ack or a fault
      pins_nx = endv;
      act_at = ticks;
      be_seen = 1'b0;
      wait_ph(2'h0, n);
      tk;
      chk("end wait", n <= 7, 1'b1);
      ob[3:0] = {data_strobe_n_o, master_hold_n_o, operand_oe_o, be_seen};
      chk("end", ob[3:0], {3'b110, endv[1:0] != 2'b11});
   endtask

   // Main sequence
   initial begin
      {reset_n_i, op_store_i, op_load_i, op_long_imm_i, op_operand_i} = 0;
      {op_op_read_i, op_op_mem_i, op_op_addr_i, op_op_wdata_i} = 0;
      {flow_change_i, flow_target_i, work_register_i, store_data_i} = 0;
      {ce_i, save_read_i, slow, lv_seen, be_seen} = 5'b11000;
      {pins, pins_nx, pre_nx} = {3{5'b10111}};
      {op_nx, ld_nx, errors, cmp_count, ticks} = 0;
      act_at = -1;
      repeat (16) @(posedge clk_i);
      #1;
      rv = {insn_read_strobe_n_o, insn_write_strobe_n_o, data_strobe_n_o,
            master_hold_n_o, execute_phase_flag_o, insn_data_bus_oe_o,
            phase_o};
      chk("reset", rv, 8'hF0);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      s_seq;
      s_mem;
      s_branch;
      for (int i = 0; i < 6; i++) begin
         s_opnd(i == 1 ? 5'b00111 : i == 2 ? 5'b11111 : 5'b10111,
                i == 4 ? 5'b10101 : i == 5 ? 5'b10110 : 5'b10011,
                {i[0], i[1], 16'h4A00 + 16'(i), 16'hB500});
      end
      stop_test;
   end
endmodule
